// ### hdl/tlptx_dev.sv
// Device end of the transmit stream port: buffers user packets and inserts its own packets.
// Functional notes
// RL1: Packet bytes travel in big-endian order.
// RL2: Byte 0 on bits 31:24, descending.
// RL3: Header is three or four words.
// RL4: User submits only well-formed packets.
// RL5: Device builds its own configuration completions.
// RL6: Device builds error messages for bad requests.
// RL7: User builds requests and its own completions.
// RL8: User completes its extended configuration accesses.
// RL9: Endpoint raises request while core packet waits.
// RL10: Steady grant: core first, user blocked.
// RL11: User may delay grant, then pulse it.
// RL12: User must not withhold grant forever.
// RL13: Root port does no base/limit filtering.
// RL14: Beat transfers only while tready high.
// RL15: User keeps tvalid high across packet.
// RL16: Last beat keep FF, or 0F low.
// RL17: User drops tvalid after final beat.
// RL18: Back-to-back packets accepted without gap.
// RL19: Three-word header, no payload: keep 0F.
// RL20: Four-word header, no payload: keep FF.
// RL21: User holds outputs while tready low.
// RL22: Non-final beats keep FF; upper ignored.
////////////////////////////////////////////////////////////////////////////////
module tlptx_dev #(
	parameter bit IS_ENDPOINT = 1'b1
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RESET_N,
	tlptx_if.dev TX_IF,
	input wire logic I_CPL_REQ,
	input wire logic [15:0] I_CPL_REQ_ID,
	input wire logic [7:0] I_CPL_TAG,
	input wire logic [2:0] I_CPL_STATUS,
	input wire logic [6:0] I_CPL_LOW_ADDR,
	input wire logic I_ERR_REQ,
	input wire logic [1:0] I_ERR_SEVERITY,
	input wire logic [15:0] I_DEV_ID,
	input wire logic I_LINK_READY,
	output logic O_LINK_VALID,
	output logic [63:0] O_LINK_DATA,
	output logic [7:0] O_LINK_KEEP,
	output logic O_LINK_LAST,
	output logic O_CPL_PENDING,
	output logic O_ERR_PENDING
);
	localparam int LW = tlptx_pkg::LVL_W;
	localparam int DEPTH = tlptx_pkg::FIFO_DEPTH;
	localparam int FW = tlptx_pkg::FIFO_W;
	localparam int PEND_CPL = 0;
	localparam int PEND_ERR = 1;

	typedef struct packed {
		logic tready;
		logic cfg_req;
		logic in_mid;
		logic out_mid;
		logic [1:0] pend;
		logic granted;
		logic core_act;
		logic core_err;
		logic core_beat;
		logic [15:0] cpl_rid;
		logic [7:0] cpl_tag;
		logic [2:0] cpl_sts;
		logic [6:0] cpl_addr;
		logic [7:0] err_code;
		logic lvalid;
		logic [63:0] ldata;
		logic [7:0] lkeep;
		logic llast;
	} tlptx_dev_s;

	tlptx_dev_s r;
	tlptx_dev_s next_r;

	logic push;
	logic [FW-1:0] fifo_in;
	logic fifo_ready;
	logic fifo_valid;
	logic fifo_pop;
	logic [FW-1:0] fifo_out;
	logic [LW-1:0] fifo_lvl;

	// More than the FIFO depth of beats can never be in flight, so the block only
	// needs its own room check; a full FIFO simply lowers tready.
	tlptx_fifo #(
		.W(FW),
		.D(DEPTH)
	) u_fifo (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RESET_N),
		.i_valid(push),
		.o_ready(fifo_ready),
		.i_data(fifo_in),
		.o_valid(fifo_valid),
		.i_ready(fifo_pop),
		.o_data(fifo_out),
		.o_level(fifo_lvl)
	);

	assign TX_IF.tready = r.tready;
	assign TX_IF.cfg_req = r.cfg_req;
	assign O_LINK_VALID = r.lvalid;
	assign O_LINK_DATA = r.ldata;
	assign O_LINK_KEEP = r.lkeep;
	assign O_LINK_LAST = r.llast;
	assign O_CPL_PENDING = r.pend[PEND_CPL];
	assign O_ERR_PENDING = r.pend[PEND_ERR];

	////////////////////////////////////////////////////////////////////////////////
	// Headers of the packets built inside the device.

	function automatic logic [7:0] sev_code(input logic [1:0] sev);
		logic [7:0] code;
		case (sev)
			tlptx_pkg::SEV_COR: code = tlptx_pkg::MSG_ERR_COR;
			tlptx_pkg::SEV_NONFATAL: code = tlptx_pkg::MSG_ERR_NONFATAL;
			default: code = tlptx_pkg::MSG_ERR_FATAL;
		endcase
		return code;
	endfunction

	logic core_start;
	logic core_sel_err;
	logic core_beat_now;
	logic [2:0] core_fmt;
	logic [31:0] dw0;
	logic [31:0] dw1;
	logic [31:0] dw2;
	logic [31:0] dw3;
	logic link_take;
	logic [LW-1:0] lvl_next;
	logic [1:0] pend_clr;

	always_comb begin
		next_r = r;
		pend_clr = '0;
		fifo_pop = 1'b0;
		// A low-keep final beat is stored with its upper half cleared. [RL22]
		push = TX_IF.tvalid && r.tready && fifo_ready; // [RL14]
		fifo_in = {tlptx_pkg::clean_data(TX_IF.tdata, TX_IF.tkeep), TX_IF.tkeep, TX_IF.tlast};
		// Structure is not checked: a malformed packet goes out as presented. [RL4]
		// No base/limit filtering is done in either configuration. [RL13]
		if (push) begin
			next_r.in_mid = !TX_IF.tlast; // [RL18]
		end

		// Completions to configuration requests take priority over error messages.
		core_start = !r.core_act && r.granted && !r.out_mid && (r.pend != '0);
		core_sel_err = r.core_act ? r.core_err : !r.pend[PEND_CPL];
		core_beat_now = r.core_act ? r.core_beat : 1'b0;
		if (core_sel_err) begin
			core_fmt = tlptx_pkg::FMT_4DW_NODATA; // [RL6]
			dw0 = {core_fmt, tlptx_pkg::TYPE_MSG_ROOT, tlptx_pkg::DW0_LOW_ZERO};
			dw1 = {I_DEV_ID, tlptx_pkg::MSG_TAG, r.err_code};
			dw2 = tlptx_pkg::DW_ZERO;
			dw3 = tlptx_pkg::DW_ZERO;
		end else begin
			core_fmt = tlptx_pkg::FMT_3DW_NODATA; // [RL5]
			dw0 = {core_fmt, tlptx_pkg::TYPE_CPL, tlptx_pkg::DW0_LOW_ZERO};
			dw1 = {I_DEV_ID, r.cpl_sts, 1'b0, tlptx_pkg::CPL_BYTE_CNT};
			dw2 = {r.cpl_rid, r.cpl_tag, 1'b0, r.cpl_addr};
			dw3 = tlptx_pkg::DW_ZERO;
		end

		// Output register toward the link; it reloads when empty or drained.
		link_take = !r.lvalid || I_LINK_READY;
		if (link_take) begin
			if (r.core_act || core_start) begin
				next_r.lvalid = 1'b1;
				next_r.core_err = core_sel_err;
				if (!core_beat_now) begin
					next_r.ldata = tlptx_pkg::beat_of(dw0, dw1); // [RL1] [RL2]
					next_r.lkeep = tlptx_pkg::KEEP_ALL;
					next_r.llast = 1'b0;
					next_r.core_act = 1'b1;
					next_r.core_beat = 1'b1;
				end else begin
					next_r.ldata = tlptx_pkg::beat_of(dw2, dw3);
					next_r.lkeep = tlptx_pkg::last_keep(core_fmt); // [RL3]
					next_r.llast = 1'b1;
					next_r.core_act = 1'b0;
					next_r.core_beat = 1'b0;
					next_r.granted = 1'b0;
					pend_clr[core_sel_err ? PEND_ERR : PEND_CPL] = 1'b1;
				end
			end else if (fifo_valid) begin
				fifo_pop = 1'b1;
				next_r.lvalid = 1'b1;
				{next_r.ldata, next_r.lkeep, next_r.llast} = fifo_out;
				next_r.out_mid = !fifo_out[0];
			end else begin
				next_r.lvalid = 1'b0;
			end
		end

		// New requests win over the clear of the same flag; fields are taken
		// only while that kind is idle or clearing, so one of each can be outstanding.
		if (I_CPL_REQ && (!r.pend[PEND_CPL] || pend_clr[PEND_CPL])) begin
			next_r.cpl_rid = I_CPL_REQ_ID;
			next_r.cpl_tag = I_CPL_TAG;
			next_r.cpl_sts = I_CPL_STATUS;
			next_r.cpl_addr = I_CPL_LOW_ADDR;
		end
		if (I_ERR_REQ && (!r.pend[PEND_ERR] || pend_clr[PEND_ERR])) begin
			next_r.err_code = sev_code(I_ERR_SEVERITY);
		end
		next_r.pend[PEND_CPL] = (r.pend[PEND_CPL] && !pend_clr[PEND_CPL]) || I_CPL_REQ;
		next_r.pend[PEND_ERR] = (r.pend[PEND_ERR] && !pend_clr[PEND_ERR]) || I_ERR_REQ;

		// One cycle of grant is remembered until the core packet has gone out. [RL11]
		if (TX_IF.cfg_gnt && (r.pend != '0) && !(r.core_act && link_take && r.core_beat)) begin
			next_r.granted = 1'b1; // [RL10]
		end
		next_r.cfg_req = IS_ENDPOINT && (next_r.pend != '0); // [RL9]

		// tready is registered, so it looks one cycle ahead at the FIFO room.
		lvl_next = fifo_lvl + LW'(push) - LW'(fifo_pop);
		next_r.tready = (lvl_next < LW'(DEPTH));
		// A granted core packet stops user packets only at a packet boundary. [RL10]
		if (next_r.granted && (next_r.pend != '0) && !next_r.in_mid) begin
			next_r.tready = 1'b0;
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule // tlptx_dev

// ### shared/tlptx_pkg.sv
// Constants, field layouts and helper functions shared by both ends of the packet transmit port.
package tlptx_pkg;
	localparam int DATA_W = 64;
	localparam int KEEP_W = 8;
	localparam int FIFO_W = DATA_W + KEEP_W + 1;
	localparam int FIFO_DEPTH = 16;
	localparam int LVL_W = 5;
	localparam logic [7:0] KEEP_ALL = 8'hff;
	localparam logic [7:0] KEEP_LOW = 8'h0f;
	localparam logic [31:0] DW_ZERO = 32'h00000000;
	// Header format and type codes of the packets that the device builds itself.
	localparam logic [2:0] FMT_3DW_NODATA = 3'h0;
	localparam logic [2:0] FMT_4DW_NODATA = 3'h1;
	localparam logic [4:0] TYPE_CPL = 5'h0a;
	localparam logic [4:0] TYPE_MSG_ROOT = 5'h10;
	localparam logic [23:0] DW0_LOW_ZERO = 24'h000000;
	localparam logic [11:0] CPL_BYTE_CNT = 12'h004;
	localparam logic [7:0] MSG_TAG = 8'h00;
	localparam logic [7:0] MSG_ERR_COR = 8'h30;
	localparam logic [7:0] MSG_ERR_NONFATAL = 8'h31;
	localparam logic [7:0] MSG_ERR_FATAL = 8'h33;
	localparam logic [1:0] SEV_COR = 2'h0;
	localparam logic [1:0] SEV_NONFATAL = 2'h1;
	// Longest time the user end withholds the grant while a core packet waits, in clock cycles.
	localparam logic [9:0] GNT_WAIT_MAX = 10'h100;

	// Bit 0 of the format field selects a four-word header.
	function automatic logic is_4dw(input logic [2:0] fmt);
		return fmt[0];
	endfunction

	// Keep value of the final beat of a payload-free packet.
	function automatic logic [7:0] last_keep(input logic [2:0] fmt);
		return is_4dw(fmt) ? KEEP_ALL : KEEP_LOW;
	endfunction

	// The earlier word of a pair sits in the low half, each word big-endian.
	function automatic logic [63:0] beat_of(input logic [31:0] first_dw, input logic [31:0] second_dw);
		return {second_dw, first_dw};
	endfunction

	// A low-keep final beat carries nothing above bit 31.
	function automatic logic [63:0] clean_data(input logic [63:0] data, input logic [7:0] keep);
		return (keep == KEEP_LOW) ? {DW_ZERO, data[31:0]} : data;
	endfunction
endpackage

// ### shared/tlptx_if.sv
// Transmit stream and core-packet arbitration signals between user logic and the device.
interface tlptx_if;
	logic tvalid;
	logic tready;
	logic [63:0] tdata;
	logic [7:0] tkeep;
	logic tlast;
	logic cfg_req;
	logic cfg_gnt;

	modport dev (
		input tvalid,
		input tdata,
		input tkeep,
		input tlast,
		input cfg_gnt,
		output tready,
		output cfg_req
	);

	modport usr (
		output tvalid,
		output tdata,
		output tkeep,
		output tlast,
		output cfg_gnt,
		input tready,
		input cfg_req
	);
endinterface

// ### hdl/tlptx_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
module tlptx_fifo #(
	parameter int W = 73,
	parameter int D = 16
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [W-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [W-1:0] o_data,
	output logic [$clog2(D):0] o_level
);
	localparam int PW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [PW-1:0] wptr;
		logic [PW-1:0] rptr;
		logic [PW:0] level;
	} tlptx_fifo_s;

	tlptx_fifo_s r;
	tlptx_fifo_s next_r;
	logic push;
	logic pop;

	assign o_ready = r.level != (PW+1)'(D);
	assign o_valid = r.level != '0;
	assign o_data = r.mem[r.rptr];
	assign o_level = r.level;

	always_comb begin
		next_r = r;
		push = i_valid && o_ready;
		pop = o_valid && i_ready;
		if (push) begin
			next_r.mem[r.wptr] = i_data;
			next_r.wptr = r.wptr + PW'(1);
		end
		if (pop) begin
			next_r.rptr = r.rptr + PW'(1);
		end
		next_r.level = r.level + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule // tlptx_fifo

// ### hdl/tlptx_usr.sv
// User end of the transmit stream port: two-entry slice onto the stream and grant policy.
module tlptx_usr (
	input wire logic I_CLK_SYS,
	input wire logic I_RESET_N,
	tlptx_if.usr TX_IF,
	input wire logic I_PKT_VALID,
	input wire logic [63:0] I_PKT_DATA,
	input wire logic [7:0] I_PKT_KEEP,
	input wire logic I_PKT_LAST,
	output logic O_PKT_READY,
	input wire logic I_GNT_ALWAYS,
	output logic O_CORE_PENDING
);
	typedef struct packed {
		logic valid;
		logic [63:0] data;
		logic [7:0] keep;
		logic last;
	} tlptx_beat_s;

	typedef struct packed {
		tlptx_beat_s main;
		tlptx_beat_s skid;
		logic ready;
		logic mid;
		logic gnt;
		logic [9:0] wait_cnt;
		logic pending;
	} tlptx_usr_s;

	tlptx_usr_s r;
	tlptx_usr_s next_r;
	tlptx_beat_s in_beat;
	logic accept;
	logic sent;

	assign TX_IF.tvalid = r.main.valid;
	assign TX_IF.tdata = r.main.data;
	assign TX_IF.tkeep = r.main.keep;
	assign TX_IF.tlast = r.main.last;
	assign TX_IF.cfg_gnt = r.gnt;
	assign O_PKT_READY = r.ready;
	assign O_CORE_PENDING = r.pending;

	////////////////////////////////////////////////////////////////////////////////
	// Stream slice: the user source builds well-formed packets itself. [RL4] [RL7] [RL8]

	always_comb begin
		next_r = r;
		in_beat.valid = 1'b1;
		in_beat.last = I_PKT_LAST;
		// Non-final beats always carry eight bytes. [RL22]
		in_beat.keep = I_PKT_LAST ? I_PKT_KEEP : tlptx_pkg::KEEP_ALL;
		// Four trailing bytes sit on bits 31:0. [RL16] [RL19] [RL20]
		in_beat.data = tlptx_pkg::clean_data(I_PKT_DATA, in_beat.keep);
		accept = I_PKT_VALID && r.ready;
		sent = r.main.valid && TX_IF.tready; // [RL14]

		// Main holds steady until taken; the skid catches a beat accepted meanwhile. [RL21]
		if (!r.main.valid || sent) begin
			if (r.skid.valid) begin
				next_r.main = r.skid; // [RL15] [RL18]
				next_r.skid = accept ? in_beat : '0;
			end else if (accept) begin
				next_r.main = in_beat;
			end else begin
				next_r.main.valid = 1'b0; // [RL17]
			end
		end else if (accept) begin
			next_r.skid = in_beat;
		end
		next_r.ready = !next_r.skid.valid;

		if (sent) begin
			next_r.mid = !r.main.last;
		end

		// Grant after our own packet, or at once in always mode; never wait past the limit.
		next_r.pending = TX_IF.cfg_req;
		if (TX_IF.cfg_req && !r.gnt && (r.wait_cnt != tlptx_pkg::GNT_WAIT_MAX)) begin
			next_r.wait_cnt = r.wait_cnt + 10'h001;
		end else if (!TX_IF.cfg_req) begin
			next_r.wait_cnt = '0;
		end
		next_r.gnt = I_GNT_ALWAYS // [RL10]
			|| (TX_IF.cfg_req && !next_r.mid) // [RL11]
			|| (r.wait_cnt == tlptx_pkg::GNT_WAIT_MAX); // [RL12]
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule // tlptx_usr

// ### dv/tlptx_checker.sv
// Concurrent checks on the stream and grant signals joining the two ends.
module tlptx_checker (
	input wire logic I_CLK_SYS,
	input wire logic I_RESET_N,
	input wire logic tvalid,
	input wire logic tready,
	input wire logic [63:0] tdata,
	input wire logic [7:0] tkeep,
	input wire logic tlast,
	input wire logic cfg_req,
	input wire logic cfg_gnt
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_RESET_N);
	logic mid;
	logic [9:0] wait_cnt;
	////////////////////////////////////////////////////////////////////////////////
	// The wait counter gives the grant bound a few cycles past the limit for registering.
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			mid <= 1'b0;
			wait_cnt <= 10'h000;
		end else begin
			if (tvalid && tready) begin
				mid <= !tlast;
			end
			wait_cnt <= (cfg_req && !cfg_gnt) ? wait_cnt + 10'h001 : 10'h000;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	hold_stall_a: assert property (tvalid && !tready |=> tvalid && $stable(tdata) && $stable(tkeep) && $stable(tlast))
		else $error("beat changed while stalled");
	keep_legal_a: assert property (tvalid |-> tkeep == 8'hff || (tlast && tkeep == 8'h0f))
		else $error("illegal keep value");
	upper_zero_a: assert property (tvalid && tkeep == 8'h0f |-> tdata[63:32] == 32'h00000000)
		else $error("upper half not clear on low keep beat");
	gnt_bound_a: assert property (wait_cnt < 10'h104)
		else $error("grant withheld too long");
	req_hold_a: assert property (cfg_req && !cfg_gnt |=> cfg_req)
		else $error("request dropped before grant");
	gnt_given_a: assert property (cfg_req && !mid && !tvalid |-> ##[0:3] cfg_gnt)
		else $error("grant not raised between packets");
	gnt_block_a: assert property ($rose(cfg_req) && cfg_gnt && !mid && !tvalid |-> ##[1:3] !tready)
		else $error("user path not blocked for core packet");
	ready_back_a: assert property (!tready |-> ##[1:400] tready)
		else $error("ready did not return");
endmodule // tlptx_checker

// ### dv/tlp_transmit_stream_port_tb.sv
// Self-checking bench joining the user end and the device end of the transmit port.
module tlp_transmit_stream_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic I_CLK_SYS = 1'b0;
	logic I_RESET_N = 1'b0;
	logic I_PKT_VALID = 1'b0, I_PKT_LAST = 1'b0, I_GNT_ALWAYS = 1'b1, I_CPL_REQ = 1'b0, I_ERR_REQ = 1'b0;
	logic I_LINK_READY = 1'b1;
	logic [63:0] I_PKT_DATA = 64'h0;
	logic [7:0] I_PKT_KEEP = 8'hff, I_CPL_TAG = 8'h00;
	logic [15:0] I_CPL_REQ_ID = 16'h0000, I_DEV_ID = 16'h0000;
	logic [2:0] I_CPL_STATUS = 3'h0;
	logic [6:0] I_CPL_LOW_ADDR = 7'h00;
	logic [1:0] I_ERR_SEVERITY = 2'h0;
	logic O_PKT_READY, O_CORE_PENDING, O_LINK_VALID, O_LINK_LAST, O_CPL_PENDING, O_ERR_PENDING;
	logic [63:0] O_LINK_DATA;
	logic [7:0] O_LINK_KEEP;
	logic hold_link = 1'b0;
	int err_count = 0;
	int checks = 0;
	int cnt;
	logic [72:0] exp_q[$];
	tlptx_if tlptx_if_inst ();
	tlptx_dev tlptx_dev_inst (.I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .TX_IF(tlptx_if_inst.dev),
		.I_CPL_REQ(I_CPL_REQ), .I_CPL_REQ_ID(I_CPL_REQ_ID), .I_CPL_TAG(I_CPL_TAG), .I_CPL_STATUS(I_CPL_STATUS),
		.I_CPL_LOW_ADDR(I_CPL_LOW_ADDR), .I_ERR_REQ(I_ERR_REQ), .I_ERR_SEVERITY(I_ERR_SEVERITY), .I_DEV_ID(I_DEV_ID),
		.I_LINK_READY(I_LINK_READY), .O_LINK_VALID(O_LINK_VALID), .O_LINK_DATA(O_LINK_DATA),
		.O_LINK_KEEP(O_LINK_KEEP), .O_LINK_LAST(O_LINK_LAST), .O_CPL_PENDING(O_CPL_PENDING),
		.O_ERR_PENDING(O_ERR_PENDING));
	tlptx_usr tlptx_usr_inst (.I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .TX_IF(tlptx_if_inst.usr),
		.I_PKT_VALID(I_PKT_VALID), .I_PKT_DATA(I_PKT_DATA), .I_PKT_KEEP(I_PKT_KEEP), .I_PKT_LAST(I_PKT_LAST),
		.O_PKT_READY(O_PKT_READY), .I_GNT_ALWAYS(I_GNT_ALWAYS), .O_CORE_PENDING(O_CORE_PENDING));
	tlptx_checker tlptx_checker_inst (.I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N), .tvalid(tlptx_if_inst.tvalid),
		.tready(tlptx_if_inst.tready), .tdata(tlptx_if_inst.tdata), .tkeep(tlptx_if_inst.tkeep),
		.tlast(tlptx_if_inst.tlast), .cfg_req(tlptx_if_inst.cfg_req), .cfg_gnt(tlptx_if_inst.cfg_gnt));
	always #10 I_CLK_SYS = ~I_CLK_SYS;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [72:0] seen, input logic [72:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic tick();
		@(posedge I_CLK_SYS);
		#1;
	endtask
	// A beat is noted before it is offered; a low-keep beat must come out with its upper half clear.
	task automatic beat(input logic [63:0] d, input logic [7:0] k, input logic l);
		int n;
		n = 0;
		I_PKT_VALID = 1'b1;
		I_PKT_DATA = d;
		I_PKT_KEEP = k;
		I_PKT_LAST = l;
		exp_q.push_back({(k == 8'h0f) ? {32'h0, d[31:0]} : d, k, l});
		while (O_PKT_READY !== 1'b1) begin
			tick();
			n++;
			if (n > 500) begin
				err_count++;
				$display("[ERR] %0t source stuck", $time);
				conclude();
			end
		end
		tick();
	endtask
	task automatic pkt(input int n, input logic [7:0] lk);
		for (int i = 0; i < n; i++)
			beat({$urandom, $urandom}, (i == n - 1) ? lk : 8'hff, i == n - 1);
	endtask
	task automatic drain();
		int n;
		n = 0;
		I_PKT_VALID = 1'b0;
		while (exp_q.size() != 0) begin
			tick();
			n++;
			if (n > 2000) begin
				err_count++;
				$display("[ERR] %0t output never drained", $time);
				conclude();
			end
		end
		repeat (4) tick();
	endtask
	task automatic req(input logic c, input logic e);
		{I_CPL_REQ_ID, I_CPL_TAG, I_CPL_STATUS, I_CPL_LOW_ADDR} = 34'({$urandom, $urandom});
		I_CPL_REQ = c;
		I_ERR_REQ = e;
		tick();
		I_CPL_REQ = 1'b0;
		I_ERR_REQ = 1'b0;
		chk(73'({O_CPL_PENDING, O_ERR_PENDING}), 73'({c, e}));
		tick();
		chk(73'(O_CORE_PENDING), 73'(1'b1));
	endtask
	// Completion goes before the error message when both wait.
	task automatic expect_core(input logic c, input logic e);
		logic [7:0] code;
		code = (I_ERR_SEVERITY == 2'h0) ? 8'h30 : (I_ERR_SEVERITY == 2'h1) ? 8'h31 : 8'h33;
		if (c) begin
			exp_q.push_back({I_DEV_ID, I_CPL_STATUS, 1'b0, tlptx_pkg::CPL_BYTE_CNT, tlptx_pkg::FMT_3DW_NODATA,
				tlptx_pkg::TYPE_CPL, tlptx_pkg::DW0_LOW_ZERO, 8'hff, 1'b0});
			exp_q.push_back({32'h0, I_CPL_REQ_ID, I_CPL_TAG, 1'b0, I_CPL_LOW_ADDR, 8'h0f, 1'b1});
		end
		if (e) begin
			exp_q.push_back({I_DEV_ID, tlptx_pkg::MSG_TAG, code, tlptx_pkg::FMT_4DW_NODATA,
				tlptx_pkg::TYPE_MSG_ROOT, tlptx_pkg::DW0_LOW_ZERO, 8'hff, 1'b0});
			exp_q.push_back({64'h0, 8'hff, 1'b1});
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge I_CLK_SYS) begin
		#1;
		I_LINK_READY = hold_link ? 1'b0 : ($urandom_range(3) != 0);
	end
	always @(posedge I_CLK_SYS) begin
		if (I_RESET_N && O_LINK_VALID === 1'b1 && I_LINK_READY === 1'b1) begin
			if (exp_q.size() == 0) begin
				err_count++;
				$display("[ERR] %0t unexpected beat", $time);
			end else
				chk({O_LINK_DATA, O_LINK_KEEP, O_LINK_LAST}, exp_q.pop_front());
		end
	end
	initial begin
		void'($urandom(32'hd1082047));
		I_DEV_ID = 16'($urandom);
		repeat (20) @(posedge I_CLK_SYS);
		#1;
		I_RESET_N = 1'b1;
		tick();
		tick();
		// Back-to-back packets of mixed length, then the two payload-free shapes.
		for (int t = 0; t < 12; t++)
			pkt($urandom_range(1, 6), $urandom_range(1) ? 8'hff : 8'h0f);
		pkt(2, 8'h0f);
		pkt(2, 8'hff);
		drain();
		$display("test 1 done");
		// The link stalls while the source keeps offering beats until refused.
		hold_link = 1'b1;
		cnt = 0;
		while (cnt < 40 && O_PKT_READY === 1'b1) begin
			beat({$urandom, $urandom}, 8'hff, 1'b0);
			cnt++;
		end
		chk(73'(cnt >= tlptx_pkg::FIFO_DEPTH && cnt < 40), 73'(1'b1));
		hold_link = 1'b0;
		beat({$urandom, $urandom}, 8'h0f, 1'b1);
		drain();
		$display("test 2 done");
		// Grant held high: core packets go first, every severity code once.
		for (int s = 0; s < 3; s++) begin
			I_ERR_SEVERITY = s[1:0];
			req(1'b1, 1'b1);
			expect_core(1'b1, 1'b1);
			drain();
			pkt(1, 8'hff);
			drain();
		end
		$display("test 3 done");
		// Grant withheld while the user packet is in flight; the completion follows it.
		I_GNT_ALWAYS = 1'b0;
		fork
			pkt(8, 8'h0f);
			begin
				repeat (3) tick();
				req(1'b1, 1'b0);
			end
		join
		expect_core(1'b1, 1'b0);
		drain();
		pkt(2, 8'h0f);
		drain();
		$display("test 4 done");
		// A second completion request while the first waits is merged into it, and both flags clear after.
		I_GNT_ALWAYS = 1'b1;
		req(1'b1, 1'b0);
		expect_core(1'b1, 1'b0);
		I_CPL_TAG = ~I_CPL_TAG;
		I_CPL_REQ = 1'b1;
		tick();
		I_CPL_REQ = 1'b0;
		drain();
		chk(73'({O_CPL_PENDING, O_ERR_PENDING}), 73'h0);
		$display("test 5 done");
		conclude();
	end
endmodule // tlp_transmit_stream_port_tb
